// >>> sle_defs.svh
// constants of the serial loader command engine
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH
`define SLE_ACK 8'hCC
`define SLE_NAK 8'h33
`define SLE_CMD_PING 8'h20
`define SLE_CMD_DOWNLOAD 8'h21
`define SLE_CMD_RUN 8'h22
`define SLE_CMD_QUERY 8'h23
`define SLE_CMD_DATA 8'h24
`define SLE_CMD_RESET 8'h25
`define SLE_LEN_SHORT 8'h03
`define SLE_LEN_RUN 8'h07
`define SLE_LEN_LONG 8'h0B
`define SLE_HEAD_BYTES 8'h03
`define SLE_BUF_LAST 4'h8
`define SLE_ST_SUCCESS 8'h40
`define SLE_ST_UNKNOWN 8'h41
`define SLE_ST_INVALID 8'h42
`define SLE_ST_FAIL 8'h43
`define SLE_FLASH_BASE 32'h0000_0000
`define SLE_FLASH_SIZE 32'h0004_0000
`define SLE_FIFO_WIDTH 8
`define SLE_FIFO_DEPTH 32
`endif

// >>> sle_pkg.sv
// types of the serial loader command engine
package sle_pkg;
  typedef enum logic [9:0] {
    SLE_HUNT = 10'h001,
    SLE_SUM = 10'h002,
    SLE_BODY = 10'h004,
    SLE_EXEC = 10'h008,
    SLE_ERASE = 10'h010,
    SLE_PROG = 10'h020,
    SLE_REPLY = 10'h040,
    SLE_STAT = 10'h080,
    SLE_HEAR = 10'h100,
    SLE_LAUNCH = 10'h200
  } sle_state_type;
  typedef enum logic [1:0] {
    SLE_KIND_ACK = 2'h0,
    SLE_KIND_NAK = 2'h1,
    SLE_KIND_STAT = 2'h2
  } sle_kind_type;
  typedef enum logic [1:0] {
    SLE_NEXT_NONE = 2'h0,
    SLE_NEXT_STAT = 2'h1,
    SLE_NEXT_RUN = 2'h2,
    SLE_NEXT_RESET = 2'h3
  } sle_follow_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] len;
  } sle_erase_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] count;
    logic [63:0] data;
  } sle_prog_type;
endpackage

// >>> sle_fifo.sv
// receive byte fifo with valid and ready on both sides
`timescale 1ns/1ps
module sle_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> sle_tx.sv
// reply sender: one ack or nak byte, or a one byte status packet
`include "sle_defs.svh"
`timescale 1ns/1ps
module sle_tx (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic go,
  input sle_pkg::sle_kind_type kind,
  input wire logic [7:0] status,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic done
);
  logic [1:0] left;
  logic [15:0] rest;

  assign tx_valid = (left != 2'h0);
  assign done = tx_valid && tx_ready && (left == 2'h1);

  // status packet: length, sum of the single data byte, the data byte
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      left <= 2'h0;
      tx_data <= 8'h00;
      rest <= 16'h0000;
    end else if (go) begin
      case (kind)
        sle_pkg::SLE_KIND_ACK: begin
          left <= 2'h1;
          tx_data <= `SLE_ACK;
        end
        sle_pkg::SLE_KIND_NAK: begin
          left <= 2'h1;
          tx_data <= `SLE_NAK;
        end
        default: begin
          left <= 2'h3;
          tx_data <= `SLE_LEN_SHORT;
          rest <= {status, status};
        end
      endcase
    end else if (tx_valid && tx_ready) begin
      left <= left - 2'h1;
      tx_data <= rest[15:8];
      rest <= {rest[7:0], 8'h00};
    end
  end
endmodule

// >>> sle_engine.sv
// command interpreter of the serial loader
//
// Behaviour
// [RULE1] ping 0x20, three bytes, sets success status and is acknowledged
// [RULE2] query 0x23 answers a one byte status packet, host then acks it
// [RULE3] download 0x21, eleven bytes, address then count, most significant first
// [RULE4] download erases the region before its acknowledge goes out
// [RULE5] download range checked against memory, result kept for the query
// [RULE6] data 0x24 valid only after download or data; address advances (code accepts it after any other command, such as a query, while armed)
// [RULE7] host sends at most eight payload bytes per data packet
// [RULE8] programming stops once the downloaded byte count is reached
// [RULE9] rejected data packet leaves the programming address unchanged
// [RULE10] result of each data chunk is kept for the query
// [RULE11] run 0x22, seven bytes, acknowledge sent before control transfer
// [RULE12] reset 0x25, three bytes, acknowledge sent before reset
// [RULE13] reset request asks for full hardware reset, not a jump
// [RULE14] acknowledge byte 0xCC, reject byte 0x33
// [RULE15] first byte is total length, second the sum, then data
// [RULE16] sum covers the data bytes only
// [RULE17] leading zero bytes skipped; first non-zero byte starts packet
// [RULE18] sum kept modulo 256
`include "sle_defs.svh"
`timescale 1ns/1ps
module sle_engine (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic erase_req,
  output sle_pkg::sle_erase_type erase_region,
  input wire logic erase_done,
  input wire logic erase_ok,
  output logic prog_req,
  output sle_pkg::sle_prog_type prog_cmd,
  input wire logic prog_done,
  input wire logic prog_ok,
  output logic run_req,
  output logic [31:0] run_addr,
  output logic reset_req,
  output logic [7:0] last_status
);
  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  sle_pkg::sle_state_type state;
  sle_pkg::sle_state_type next_state;
  sle_pkg::sle_follow_type follow;
  sle_pkg::sle_follow_type next_follow;
  sle_pkg::sle_kind_type kind;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic take;
  logic go;
  logic tx_done;
  logic [7:0] next_status;
  logic status_we;

  // the fifo lets bytes pile up while erase or programming is slow
  sle_fifo #(.WIDTH(`SLE_FIFO_WIDTH), .DEPTH(`SLE_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  assign f_ready = (state == sle_pkg::SLE_HUNT) || (state == sle_pkg::SLE_SUM) ||
                   (state == sle_pkg::SLE_BODY) || (state == sle_pkg::SLE_HEAR);
  assign take = f_valid && f_ready;

  // ----------------------------------------------------------------
  // packet capture
  // ----------------------------------------------------------------
  logic [7:0] pkt_len;
  logic [7:0] pkt_sum;
  logic [7:0] calc_sum;
  logic [7:0] data_cnt;
  logic [7:0] buf_mem [0:8];
  logic [63:0] payload;
  logic [7:0] cmd;
  logic pkt_ok;
  logic body_last;

  assign cmd = buf_mem[0];
  assign body_last = (8'(data_cnt + `SLE_HEAD_BYTES) == pkt_len);
  // [RULE16] the stored sum is compared against data bytes only
  assign pkt_ok = (calc_sum == pkt_sum) && (pkt_len >= `SLE_LEN_SHORT) &&
                  (pkt_len <= `SLE_LEN_LONG);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pkt_len <= 8'h00;
      pkt_sum <= 8'h00;
      calc_sum <= 8'h00;
      data_cnt <= 8'h00;
    end else if (take && (state == sle_pkg::SLE_HUNT) && (f_data != 8'h00)) begin
      pkt_len <= f_data; // RULE15 RULE17
      calc_sum <= 8'h00;
      data_cnt <= 8'h00;
    end else if (take && (state == sle_pkg::SLE_SUM)) begin
      pkt_sum <= f_data; // RULE15
    end else if (take && (state == sle_pkg::SLE_BODY)) begin
      calc_sum <= 8'(calc_sum + f_data); // RULE18
      data_cnt <= 8'(data_cnt + 8'h01);
    end
  end

  // oversized packets are drained but only the first nine bytes kept
  always_ff @(posedge mclk) begin
    if (take && (state == sle_pkg::SLE_BODY) && (data_cnt <= 8'(`SLE_BUF_LAST))) begin
      buf_mem[data_cnt[3:0]] <= f_data;
    end
  end

  // data byte 0 of the chunk lands in the top byte of the payload
  for (genvar g = 0; g < 8; g++) begin : g_pay
    assign payload[63-8*g -: 8] = buf_mem[g+1];
  end

  // ----------------------------------------------------------------
  // command decode and sequencing
  // ----------------------------------------------------------------
  logic [31:0] arg_a;
  logic [31:0] arg_b;
  logic [32:0] arg_end;
  logic range_ok;
  logic armed;
  logic [31:0] prog_addr;
  logic [31:0] remaining;
  logic [3:0] chunk;
  logic [3:0] next_chunk;

  assign arg_a = payload[63:32]; // RULE3
  assign arg_b = payload[31:0];
  assign arg_end = {1'b0, arg_a} + {1'b0, arg_b};
  // [RULE5] region must lie inside the memory
  assign range_ok = (arg_a >= `SLE_FLASH_BASE) &&
                    (arg_end <= ({1'b0, `SLE_FLASH_BASE} + {1'b0, `SLE_FLASH_SIZE}));

  always_comb begin
    next_state = state;
    next_follow = follow;
    next_status = last_status;
    status_we = 1'b0;
    go = 1'b0;
    kind = sle_pkg::SLE_KIND_ACK;
    next_chunk = chunk;
    case (state)
      sle_pkg::SLE_HUNT: begin
        if (take && (f_data != 8'h00)) begin
          next_state = sle_pkg::SLE_SUM; // RULE17
        end
      end
      sle_pkg::SLE_SUM: begin
        if (take) begin
          next_state = (pkt_len <= 8'h02) ? sle_pkg::SLE_EXEC : sle_pkg::SLE_BODY;
        end
      end
      sle_pkg::SLE_BODY: begin
        if (take && body_last) begin
          next_state = sle_pkg::SLE_EXEC;
        end
      end
      sle_pkg::SLE_EXEC: begin
        next_state = sle_pkg::SLE_REPLY;
        next_follow = sle_pkg::SLE_NEXT_NONE;
        go = 1'b1;
        status_we = 1'b1;
        next_status = `SLE_ST_SUCCESS;
        if (!pkt_ok) begin
          kind = sle_pkg::SLE_KIND_NAK; // RULE14
          status_we = 1'b0;
        end else begin
          case (cmd)
            `SLE_CMD_PING: begin
              next_status = `SLE_ST_SUCCESS; // RULE1
            end
            `SLE_CMD_QUERY: begin
              status_we = 1'b0;
              next_follow = sle_pkg::SLE_NEXT_STAT; // RULE2
            end
            `SLE_CMD_DOWNLOAD: begin
              if ((pkt_len == `SLE_LEN_LONG) && range_ok) begin
                go = 1'b0; // RULE4
                status_we = 1'b0;
                next_state = sle_pkg::SLE_ERASE;
              end else begin
                next_status = `SLE_ST_INVALID; // RULE5
              end
            end
            `SLE_CMD_DATA: begin
              next_chunk = 4'(pkt_len - `SLE_HEAD_BYTES);
              if (32'(next_chunk) > remaining) begin
                next_chunk = remaining[3:0]; // RULE8
              end
              if (!armed) begin
                kind = sle_pkg::SLE_KIND_NAK; // RULE6
                next_status = `SLE_ST_INVALID;
              end else if (next_chunk != 4'h0) begin
                go = 1'b0;
                status_we = 1'b0;
                next_state = sle_pkg::SLE_PROG;
              end
            end
            `SLE_CMD_RUN: begin
              if (pkt_len == `SLE_LEN_RUN) begin
                next_follow = sle_pkg::SLE_NEXT_RUN; // RULE11
              end else begin
                next_status = `SLE_ST_INVALID;
              end
            end
            `SLE_CMD_RESET: begin
              next_follow = sle_pkg::SLE_NEXT_RESET; // RULE12
            end
            default: begin
              next_status = `SLE_ST_UNKNOWN;
            end
          endcase
        end
      end
      sle_pkg::SLE_ERASE: begin
        if (erase_done) begin
          go = 1'b1; // RULE4
          status_we = 1'b1;
          next_status = erase_ok ? `SLE_ST_SUCCESS : `SLE_ST_FAIL;
          next_state = sle_pkg::SLE_REPLY;
        end
      end
      sle_pkg::SLE_PROG: begin
        if (prog_done) begin
          go = 1'b1;
          status_we = 1'b1; // RULE10
          next_status = prog_ok ? `SLE_ST_SUCCESS : `SLE_ST_FAIL;
          kind = prog_ok ? sle_pkg::SLE_KIND_ACK : sle_pkg::SLE_KIND_NAK;
          next_state = sle_pkg::SLE_REPLY;
        end
      end
      sle_pkg::SLE_REPLY: begin
        if (tx_done) begin
          case (follow)
            sle_pkg::SLE_NEXT_STAT: begin
              go = 1'b1; // RULE2
              kind = sle_pkg::SLE_KIND_STAT;
              next_state = sle_pkg::SLE_STAT;
            end
            sle_pkg::SLE_NEXT_RUN, sle_pkg::SLE_NEXT_RESET: begin
              next_state = sle_pkg::SLE_LAUNCH;
            end
            default: begin
              next_state = sle_pkg::SLE_HUNT;
            end
          endcase
        end
      end
      sle_pkg::SLE_STAT: begin
        if (tx_done) begin
          next_state = sle_pkg::SLE_HEAR;
        end
      end
      sle_pkg::SLE_HEAR: begin
        // host answer to the status packet; a nak needs a new query
        if (take && (f_data != 8'h00)) begin
          next_state = sle_pkg::SLE_HUNT; // RULE2 RULE17
        end
      end
      sle_pkg::SLE_LAUNCH: begin
        next_state = sle_pkg::SLE_HUNT;
      end
      default: begin
        next_state = sle_pkg::SLE_HUNT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= sle_pkg::SLE_HUNT;
      follow <= sle_pkg::SLE_NEXT_NONE;
      chunk <= 4'h0;
    end else begin
      state <= next_state;
      follow <= next_follow;
      chunk <= next_chunk;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      last_status <= `SLE_ST_SUCCESS;
    end else if (status_we) begin
      last_status <= next_status; // RULE5 RULE10
    end
  end

  // ----------------------------------------------------------------
  // programming window
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      armed <= 1'b0;
      prog_addr <= 32'h0000_0000;
      remaining <= 32'h0000_0000;
    end else if (state == sle_pkg::SLE_ERASE && erase_done) begin
      armed <= erase_ok && (arg_b != 32'h0000_0000); // RULE6
      prog_addr <= arg_a;
      remaining <= arg_b;
    end else if (state == sle_pkg::SLE_EXEC && pkt_ok && cmd == `SLE_CMD_DOWNLOAD) begin
      armed <= 1'b0;
    end else if (state == sle_pkg::SLE_PROG && prog_done && prog_ok) begin
      prog_addr <= prog_addr + 32'(chunk); // RULE6 RULE9
      remaining <= remaining - 32'(chunk);
      armed <= (remaining != 32'(chunk)); // RULE8
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      erase_req <= 1'b0;
      prog_req <= 1'b0;
    end else begin
      erase_req <= (next_state == sle_pkg::SLE_ERASE);
      prog_req <= (next_state == sle_pkg::SLE_PROG);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      erase_region <= '0;
      prog_cmd <= '0;
    end else begin
      if (state == sle_pkg::SLE_EXEC) begin
        erase_region <= '{addr: arg_a, len: arg_b};
      end
      if (state == sle_pkg::SLE_EXEC) begin
        prog_cmd <= '{addr: prog_addr, count: next_chunk, data: payload};
      end
    end
  end

  // ----------------------------------------------------------------
  // replies and hand-off
  // ----------------------------------------------------------------
  sle_tx u_tx (
    .mclk(mclk),
    .rst_b(rst_b),
    .go(go),
    .kind(kind),
    .status(last_status),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .done(tx_done)
  );

  // both hand-offs fire only once the acknowledge has left
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      run_req <= 1'b0;
      reset_req <= 1'b0;
      run_addr <= 32'h0000_0000;
    end else begin
      run_req <= (state == sle_pkg::SLE_REPLY) && tx_done &&
                 (follow == sle_pkg::SLE_NEXT_RUN); // RULE11
      reset_req <= (state == sle_pkg::SLE_REPLY) && tx_done &&
                   (follow == sle_pkg::SLE_NEXT_RESET); // RULE12 RULE13
      if (state == sle_pkg::SLE_EXEC) begin
        run_addr <= arg_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_nak_bad_packet: assert property ( // RULE16
    state == sle_pkg::SLE_EXEC && !pkt_ok |=> tx_valid && tx_data == `SLE_NAK
  ) else $error("bad packet not rejected");
  a_ping_ack: assert property ( // RULE1
    state == sle_pkg::SLE_EXEC && pkt_ok && cmd == `SLE_CMD_PING
    |=> tx_data == `SLE_ACK && last_status == `SLE_ST_SUCCESS
  ) else $error("ping not acknowledged");
  a_erase_before_ack: assert property ( // RULE4
    state == sle_pkg::SLE_ERASE |-> !tx_valid && erase_req
  ) else $error("reply during erase");
  a_addr_hold_nak: assert property ( // RULE9
    state == sle_pkg::SLE_PROG && prog_done && !prog_ok
    |=> prog_addr == $past(prog_addr) && tx_data == `SLE_NAK
  ) else $error("address moved on reject");
  a_count_stop: assert property ( // RULE8
    armed |-> remaining != 32'h0000_0000
  ) else $error("armed with nothing left");
  a_run_after_ack: assert property ( // RULE11
    $rose(run_req) |-> $past(tx_done) && $past(follow) == sle_pkg::SLE_NEXT_RUN
  ) else $error("run before ack");
  a_reset_pulse: assert property ( // RULE12
    reset_req |-> $past(tx_done) ##1 !reset_req
  ) else $error("reset not a pulse after ack");
  a_stat_packet: assert property ( // RULE2
    state == sle_pkg::SLE_REPLY && tx_done && follow == sle_pkg::SLE_NEXT_STAT
    |=> tx_valid && tx_data == `SLE_LEN_SHORT
  ) else $error("status packet missing");
  a_zero_skip: assert property ( // RULE17
    state == sle_pkg::SLE_HUNT && take && f_data == 8'h00 |=> state == sle_pkg::SLE_HUNT
  ) else $error("zero byte started packet");

  c_ping: cover property (state == sle_pkg::SLE_EXEC && pkt_ok && cmd == `SLE_CMD_PING);
  c_erase: cover property (state == sle_pkg::SLE_ERASE && erase_done && erase_ok);
  c_prog: cover property (state == sle_pkg::SLE_PROG && prog_done && prog_ok);
  c_run: cover property (run_req);
endmodule

// >>> sle_host_model.sv
// host side model: sends command packets and takes reply bytes
`timescale 1ns/1ps
module sle_host_model (
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic hung
);
  // ----------------------------------------
  // byte and packet tasks
  // ----------------------------------------
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    tx_ready = 1'b0;
    hung = 1'b0;
  end
  // held until an edge sees ready; sampled settled, one ns after the edge
  task automatic put(input logic [7:0] b);
    logic t;
    rx_valid = 1'b1;
    rx_data = b;
    for (int n = 0; n < 3000; n++) begin
      t = rx_ready;
      @(posedge mclk);
      #1;
      if (t === 1'b1) return;
    end
    hung = 1'b1;
  endtask
  // released line shows the inverse so a stale byte cannot pass
  task automatic pkt(input logic [7:0] cmd, input logic [63:0] arg, input int n,
                     input int pad, input logic bad);
    logic [7:0] sum;
    sum = cmd;
    for (int i = 0; i < n; i++) sum += arg[8*i +: 8];
    tx_ready = 1'b0;
    repeat (pad) put(8'h00);
    put(8'(n + 3));
    put(sum ^ {7'h00, bad});
    put(cmd);
    for (int i = n - 1; i >= 0; i--) put(arg[8*i +: 8]);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  task automatic ack;
    put(8'hCC);
    rx_valid = 1'b0;
    rx_data = 8'h33;
    // let an edge pass so a following packet does not re-raise valid at once
    @(posedge mclk);
    #1;
  endtask
  task automatic get(output logic [7:0] b);
    logic t;
    tx_ready = 1'b1;
    for (int n = 0; n < 3000; n++) begin
      t = tx_valid;
      b = tx_data;
      @(posedge mclk);
      #1;
      if (t === 1'b1 && b !== 8'h00) return;
    end
    hung = 1'b1;
  endtask
  // zeros pushed every cycle; counts how many the fifo took
  task automatic fill(input int n, output int acc);
    acc = 0;
    rx_valid = 1'b1;
    rx_data = 8'h00;
    repeat (n) begin
      if (rx_ready === 1'b1) acc++;
      @(posedge mclk);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = 8'hFF;
  endtask
endmodule

// >>> serial_loader_command_engine_tb_top.sv
// testbench of the serial loader command engine
`include "sle_defs.svh"
`timescale 1ns/1ps
module serial_loader_command_engine_tb_top;
  // ----------------------------------------
  // clock, design, flash responder
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, hung;
  logic [7:0] rx_data, tx_data, last_status;
  logic erase_req, prog_req, run_req, reset_req;
  logic erase_done = 1'b0;
  logic prog_done = 1'b0;
  logic flash_ok = 1'b1;
  int flash_wait = 3;
  sle_pkg::sle_erase_type erase_region, seen_region;
  sle_pkg::sle_prog_type prog_cmd, seen_prog;
  logic [31:0] run_addr, run_seen;
  int errors, tests_run, wait_cnt, erase_cnt, prog_cnt, run_cnt, reset_cnt;
  initial forever #20 mclk = ~mclk;
  sle_engine uut (.mclk(mclk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .erase_req(erase_req), .erase_region(erase_region), .erase_done(erase_done),
    .erase_ok(flash_ok), .prog_req(prog_req), .prog_cmd(prog_cmd), .prog_done(prog_done),
    .prog_ok(flash_ok), .run_req(run_req), .run_addr(run_addr), .reset_req(reset_req),
    .last_status(last_status));
  sle_host_model h (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .hung(hung));
  // flash side answers after flash_wait cycles of a held request
  always @(posedge mclk) begin
    if (run_req === 1'b1) begin
      run_cnt++;
      run_seen = run_addr;
    end
    if (reset_req === 1'b1) reset_cnt++;
    #1;
    erase_done = 1'b0;
    prog_done = 1'b0;
    if (erase_req === 1'b1 || prog_req === 1'b1) wait_cnt++;
    else wait_cnt = 0;
    if (wait_cnt == flash_wait) begin
      wait_cnt = 0;
      erase_done = erase_req;
      prog_done = prog_req;
      if (erase_req) erase_cnt++;
      if (erase_req) seen_region = erase_region;
      if (prog_req) prog_cnt++;
      if (prog_req) seen_prog = prog_cmd;
    end
  end
  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  task automatic stop_test;
    if (hung === 1'b1) errors++;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("BAD at %0t seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic exp(input logic [7:0] want);
    logic [7:0] b;
    h.get(b);
    check({24'h0, b}, {24'h0, want});
  endtask
  task automatic query(input logic [7:0] st);
    h.pkt(`SLE_CMD_QUERY, 64'h0, 0, 0, 1'b0);
    exp(`SLE_ACK);
    exp(`SLE_LEN_SHORT);
    exp(st);
    exp(st);
    h.ack();
  endtask
  task automatic send(input logic [7:0] cmd, input logic [63:0] a, input int n,
                      input logic [7:0] reply);
    h.pkt(cmd, a, n, 0, 1'b0);
    exp(reply);
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ping;
    check({24'h0, last_status}, {24'h0, `SLE_ST_SUCCESS});
    h.pkt(`SLE_CMD_PING, 64'h0, 0, 2, 1'b0);
    exp(`SLE_ACK);
    query(`SLE_ST_SUCCESS);
    h.pkt(`SLE_CMD_PING, 64'h0, 0, 0, 1'b1);
    exp(`SLE_NAK);
    send(8'h30, 64'h0, 0, `SLE_ACK);
    query(`SLE_ST_UNKNOWN);
    $display("done ping");
  endtask
  task automatic t_download;
    int acc;
    send(`SLE_CMD_DATA, 64'h1, 8, `SLE_NAK);
    query(`SLE_ST_INVALID);
    send(`SLE_CMD_DOWNLOAD, {32'h0004_0000, 32'h4}, 8, `SLE_ACK);
    query(`SLE_ST_INVALID);
    check(erase_cnt, 0);
    flash_wait = 80;
    h.pkt(`SLE_CMD_DOWNLOAD, {32'h0000_1000, 32'hA}, 8, 0, 1'b0);
    for (int n = 0; n < 200 && erase_req !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    check(32'(erase_req), 32'h1);
    h.fill(40, acc);
    check(acc, `SLE_FIFO_DEPTH);
    exp(`SLE_ACK);
    check(erase_cnt, 1);
    check(seen_region.addr, 32'h0000_1000);
    check(seen_region.len, 32'hA);
    query(`SLE_ST_SUCCESS);
    $display("done download");
  endtask
  task automatic t_data;
    flash_wait = 3;
    send(`SLE_CMD_DATA, 64'h0102_0304_0506_0708, 8, `SLE_ACK);
    check(seen_prog.addr, 32'h1000);
    check(32'(seen_prog.count), 8);
    check(seen_prog.data[63:32], 32'h0102_0304);
    query(`SLE_ST_SUCCESS);
    flash_ok = 1'b0;
    send(`SLE_CMD_DATA, 64'h1112_1314_1516_1718, 8, `SLE_NAK);
    check(seen_prog.addr, 32'h1008);
    query(`SLE_ST_FAIL);
    flash_ok = 1'b1;
    send(`SLE_CMD_DATA, 64'h1112_1314_1516_1718, 8, `SLE_ACK);
    check(seen_prog.addr, 32'h1008);
    check(32'(seen_prog.count), 2);
    check(seen_prog.data[63:48], 16'h1112);
    send(`SLE_CMD_DATA, 64'h2, 8, `SLE_NAK);
    query(`SLE_ST_INVALID);
    check(prog_cnt, 3);
    $display("done data");
  endtask
  task automatic t_reset_run;
    send(`SLE_CMD_RESET, 64'h0, 0, `SLE_ACK);
    check(reset_cnt, 0);
    repeat (4) @(posedge mclk);
    #1;
    check(reset_cnt, 1);
    do_reset();
    send(`SLE_CMD_RUN, 64'h0001_2345, 4, `SLE_ACK);
    check(run_cnt, 0);
    repeat (4) @(posedge mclk);
    #1;
    check(run_cnt, 1);
    check(run_seen, 32'h0001_2345);
    $display("done reset and run");
  endtask
  initial begin
    do_reset();
    t_ping();
    t_download();
    t_data();
    t_reset_run();
    stop_test();
  end
  initial begin
    for (int n = 0; n < 20000; n++) begin
      @(posedge mclk);
      if (hung) break;
    end
    errors++;
    stop_test();
  end
endmodule
